// file: shared/prsc_pkg.sv
package prsc_pkg;

    // register page addresses
    localparam logic [15:0] PRSC_ADDR_PRE_PIN = 16'h0087;
    localparam logic [15:0] PRSC_ADDR_PIN     = 16'h0088;
    localparam logic [15:0] PRSC_ADDR_LATCH   = 16'h0089;
    localparam logic [15:0] PRSC_ADDR_ACT     = 16'h008A;
    localparam logic [15:0] PRSC_ADDR_MASK    = 16'h008B;
    localparam logic [15:0] PRSC_ADDR_POL     = 16'h008C;
    localparam logic [15:0] PRSC_ADDR_CTRL    = 16'h008D;
    localparam logic [15:0] PRSC_ADDR_LAST    = 16'h008F;

    // function command codes
    localparam logic [7:0] PRSC_CMD_READ_REGS = 8'hF0;
    localparam logic [7:0] PRSC_CMD_CH_READ   = 8'hF5;
    localparam logic [7:0] PRSC_CMD_WR_SEARCH = 8'hCC;

    // control_and_status fields
    localparam int PRSC_BIT_SRC = 0;
    localparam int PRSC_BIT_CMB = 1;
    localparam int PRSC_BIT_RPF = 2;
    localparam int PRSC_BIT_POR = 3;
    localparam int PRSC_BIT_EXT = 7;

    localparam logic [3:0] PRSC_CTRL_RESET  = 4'h8;
    localparam logic [7:0] PRSC_MASK_RESET  = 8'h00;
    localparam logic [7:0] PRSC_POL_RESET   = 8'h00;
    localparam logic [7:0] PRSC_UNDEF_BYTE  = 8'h00;
    localparam logic [7:0] PRSC_ONES_BYTE   = 8'hFF;

    localparam logic [4:0]  PRSC_CH_LAST    = 5'd31;
    localparam logic [2:0]  PRSC_STROBE_END = 3'd1;
    localparam logic [2:0]  PRSC_BIT_MSB    = 3'd7;
    localparam logic [15:0] PRSC_CRC_POLY   = 16'hA001;
    localparam logic [15:0] PRSC_CRC_RESET  = 16'h0000;

    localparam int PRSC_BYTE_W     = 8;
    localparam int PRSC_FIFO_DEPTH = 16;

    typedef enum logic [3:0] {
        PRSC_IDLE    = 4'b0000,
        PRSC_ADDR_LO = 4'b0001,
        PRSC_ADDR_HI = 4'b0011,
        PRSC_RD_DATA = 4'b0010,
        PRSC_RD_CRC  = 4'b0110,
        PRSC_ONES    = 4'b0111,
        PRSC_CH_DATA = 4'b0101,
        PRSC_CH_CRC  = 4'b0100,
        PRSC_WR_DATA = 4'b1100,
        PRSC_DISCARD = 4'b1101
    } prsc_st_type;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } prsc_byte_type;

    typedef struct packed {
        logic valid;
        logic bit_val;
    } prsc_tx_type;

endpackage

// file: verilog/prsc_crc16.sv
`timescale 1ns/1ps
module prsc_crc16 (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_clear,
    input  wire logic        i_add,
    input  wire logic [7:0]  i_byte,
    output logic      [15:0] o_crc
);
    import prsc_pkg::*;

    typedef struct packed {
        logic [15:0] crc;
    } prsc_crc_state_type;

    prsc_crc_state_type s;
    prsc_crc_state_type next_s;

    // lsb first, reflected generator
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r[0] ^ d[i]) ? ((r >> 1) ^ PRSC_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    always_comb begin
        next_s = s;
        if (i_clear) begin
            next_s.crc = PRSC_CRC_RESET;
        end
        if (i_add) begin
            next_s.crc = crc_byte(i_clear ? PRSC_CRC_RESET : s.crc, i_byte);
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            s.crc <= PRSC_CRC_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign o_crc = s.crc;
endmodule

// file: verilog/prsc_fifo.sv
`timescale 1ns/1ps
module prsc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             i_ref_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_flush,
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    output logic                  o_out_valid,
    output logic      [WIDTH-1:0] o_out_data,
    input  wire logic             i_out_ready
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wr;
        logic [PW-1:0]               rd;
        logic [CW-1:0]               cnt;
        logic                        ready;
    } prsc_fifo_state_type;

    prsc_fifo_state_type s;
    prsc_fifo_state_type next_s;
    logic                push;
    logic                pop;

    always_comb begin
        next_s = s;
        push   = i_in_valid && s.ready;
        pop    = i_out_ready && (s.cnt != '0);
        if (push) begin
            next_s.mem[s.wr] = i_in_data;
            next_s.wr        = s.wr + 1'b1;
        end
        if (pop) begin
            next_s.rd = s.rd + 1'b1;
        end
        next_s.cnt = s.cnt + CW'(push) - CW'(pop);
        if (i_flush) begin
            next_s.wr  = '0;
            next_s.rd  = '0;
            next_s.cnt = '0;
        end
        next_s.ready = (next_s.cnt != FULL);
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            s <= '{default: '0, ready: 1'b1};
        end else begin
            s <= next_s;
        end
    end

    assign o_in_ready  = s.ready;
    assign o_out_valid = (s.cnt != '0);
    assign o_out_data  = s.mem[s.rd];
endmodule

// file: verilog/prsc_ctrl.sv
// Overview of operation
// - control_and_status changes only through the search register write command.
// - after power-on reset without supply, control_and_status reads 08h.
// - bits 4 to 6 of control_and_status always read zero.
// - bit 0 picks pins or activity latches as search input.
// - bit 1 picks OR or AND of per-channel results.
// - with one enabled channel the combine mode makes no difference.
// - bit 2 makes the reset/strobe pin a reset input or strobe output.
// - power-on flag set at reset, afterwards only cleared by a write.
// - power-on flag set means every conditional search is answered.
// - bit 7 reads external supply presence and cannot be written.
// - mask enables each channel, polarity gives its qualifying level.
// - OR mode qualifies if any enabled channel matches its polarity.
// - AND mode qualifies only if all enabled channels match.
// - speed is standard until overdrive is explicitly entered.
// - register read returns bytes from target address up to 008Fh.
// - then inverted CRC16 of command, address and data bytes.
// - after that CRC every read slot answers one until bus reset.
// - pins sampled at MSB of address high byte or of byte 0087h.
// - channel read streams pin bytes, inverted CRC16 after every 32.
// - a bus reset aborts any command in progress.
// - first CRC covers command and 32 samples, later ones 32 samples.
// - strobe pulses low during the two low bits of each channel read pin byte.
`timescale 1ns/1ps
module prsc_ctrl (
    input  wire logic                   i_ref_clk,
    input  wire logic                   i_rst_n,
    input  wire logic                   i_bus_reset,
    input  wire logic                   i_od_enter,
    input  wire logic                   i_od_leave,
    input  wire prsc_pkg::prsc_byte_type i_rx,
    output logic                        o_rx_ready,
    input  wire logic                   i_read_slot,
    output prsc_pkg::prsc_tx_type       o_tx,
    input  wire logic [7:0]             i_port_pins,
    input  wire logic [7:0]             i_output_latch,
    input  wire logic [7:0]             i_activity,
    input  wire logic                   i_ext_supply,
    input  wire logic                   i_reset_strobe_pin_in,
    output logic                        o_reset_strobe_pin_out,
    output logic                        o_reset_strobe_pin_oe,
    output logic                        o_pin_reset,
    output logic                        o_search_response,
    output logic                        o_overdrive_flag
);
    import prsc_pkg::*;

    typedef struct packed {
        prsc_st_type st;
        logic [7:0]  cmd;
        logic [15:0] addr;
        logic [7:0]  shreg;
        logic [2:0]  bit_idx;
        logic [4:0]  cnt;
        logic        crc_hi;
        logic        addcrc;
        logic        strobe;
        logic [7:0]  pins;
        logic [7:0]  mask;
        logic [7:0]  pol;
        logic [3:0]  ctl;
        logic        od;
        logic        resp;
        logic        pin_reset;
        prsc_tx_type tx;
    } prsc_state_type;

    localparam prsc_state_type STATE_RESET = '{
        st:    PRSC_IDLE,
        mask:  PRSC_MASK_RESET,
        pol:   PRSC_POL_RESET,
        ctl:   PRSC_CTRL_RESET,
        shreg: PRSC_ONES_BYTE,
        tx:    '{valid: 1'b0, bit_val: 1'b1},
        default: '0
    };

    prsc_state_type s;
    prsc_state_type next_s;

    logic        fifo_valid;
    logic [7:0]  fifo_data;
    logic        fifo_ready;
    logic        crc_clr;
    logic        crc_add;
    logic [7:0]  crc_in;
    logic [15:0] crc;
    logic [7:0]  pins_now;
    logic [7:0]  src;
    logic [7:0]  match;

    // byte at an address of the register page
    function automatic logic [7:0] reg_byte(input logic [15:0] a, input logic [7:0] pins,
                                            input prsc_state_type st, input logic ext);
        logic [7:0] v;
        v = PRSC_UNDEF_BYTE;
        unique case (a)
            PRSC_ADDR_PIN:   v = pins;
            PRSC_ADDR_LATCH: v = i_output_latch;
            PRSC_ADDR_ACT:   v = i_activity;
            PRSC_ADDR_MASK:  v = st.mask;
            PRSC_ADDR_POL:   v = st.pol;
            PRSC_ADDR_CTRL:  v = {ext, 3'b000, st.ctl};
            default:         v = (a > PRSC_ADDR_CTRL) ? PRSC_ONES_BYTE : PRSC_UNDEF_BYTE;
        endcase
        return v;
    endfunction

    prsc_fifo #(
        .WIDTH (PRSC_BYTE_W),
        .DEPTH (PRSC_FIFO_DEPTH)
    ) u_rx_fifo (
        .i_ref_clk   (i_ref_clk),
        .i_rst_n     (i_rst_n),
        .i_flush     (i_bus_reset),
        .i_in_valid  (i_rx.valid),
        .i_in_data   (i_rx.data),
        .o_in_ready  (o_rx_ready),
        .o_out_valid (fifo_valid),
        .o_out_data  (fifo_data),
        .i_out_ready (fifo_ready)
    );

    prsc_crc16 u_crc (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_clear   (crc_clr),
        .i_add     (crc_add),
        .i_byte    (crc_in),
        .o_crc     (crc)
    );

    always_comb begin
        next_s          = s;
        next_s.tx.valid = 1'b0;
        next_s.addcrc   = 1'b0;
        crc_clr         = 1'b0;
        crc_add         = s.addcrc;
        crc_in          = s.shreg;
        pins_now        = s.pins;
        fifo_ready      = s.st inside {PRSC_IDLE, PRSC_ADDR_LO, PRSC_ADDR_HI,
                                       PRSC_WR_DATA, PRSC_DISCARD};

        // bytes written by the master
        if (fifo_valid && fifo_ready) begin
            unique case (s.st)
                PRSC_IDLE: begin
                    crc_clr    = 1'b1;
                    crc_add    = 1'b1;
                    crc_in     = fifo_data;
                    next_s.cmd = fifo_data;
                    if (fifo_data == PRSC_CMD_READ_REGS || fifo_data == PRSC_CMD_WR_SEARCH) begin
                        next_s.st = PRSC_ADDR_LO;
                    end else if (fifo_data == PRSC_CMD_CH_READ) begin
                        next_s.st      = PRSC_CH_DATA;
                        next_s.shreg   = i_port_pins;
                        next_s.addcrc  = 1'b1;
                        next_s.cnt     = '0;
                        next_s.bit_idx = '0;
                        next_s.strobe  = s.ctl[PRSC_BIT_RPF];
                    end else begin
                        next_s.st = PRSC_DISCARD;
                    end
                end
                PRSC_ADDR_LO: begin
                    crc_add          = 1'b1;
                    crc_in           = fifo_data;
                    next_s.addr[7:0] = fifo_data;
                    next_s.st        = PRSC_ADDR_HI;
                end
                PRSC_ADDR_HI: begin
                    crc_add           = 1'b1;
                    crc_in            = fifo_data;
                    next_s.addr[15:8] = fifo_data;
                    next_s.bit_idx    = '0;
                    if ({fifo_data, s.addr[7:0]} == PRSC_ADDR_PIN) begin
                        pins_now    = i_port_pins;
                        next_s.pins = i_port_pins;
                    end
                    if (s.cmd == PRSC_CMD_WR_SEARCH) begin
                        next_s.st = PRSC_WR_DATA;
                    end else if ({fifo_data, s.addr[7:0]} > PRSC_ADDR_LAST) begin
                        next_s.st    = PRSC_ONES;
                        next_s.shreg = PRSC_ONES_BYTE;
                    end else begin
                        next_s.st     = PRSC_RD_DATA;
                        next_s.shreg  = reg_byte({fifo_data, s.addr[7:0]}, pins_now, s,
                                                 i_ext_supply);
                        next_s.addcrc = 1'b1;
                    end
                end
                PRSC_WR_DATA: begin
                    next_s.addr = s.addr + 16'h0001;
                    unique case (s.addr)
                        PRSC_ADDR_MASK: next_s.mask = fifo_data;
                        PRSC_ADDR_POL:  next_s.pol  = fifo_data;
                        PRSC_ADDR_CTRL: begin
                            // low three bits load, the power-on flag can only drop
                            next_s.ctl = {s.ctl[PRSC_BIT_POR] & fifo_data[PRSC_BIT_POR],
                                          fifo_data[2:0]};
                            next_s.st  = PRSC_DISCARD;
                        end
                        default: next_s.st = PRSC_DISCARD;
                    endcase
                end
                default: begin
                end
            endcase
        end

        // read time slots
        if (i_read_slot) begin
            next_s.tx.valid   = 1'b1;
            next_s.tx.bit_val = 1'b1;
            if (s.st inside {PRSC_RD_DATA, PRSC_RD_CRC, PRSC_ONES, PRSC_CH_DATA,
                             PRSC_CH_CRC}) begin
                next_s.tx.bit_val = s.shreg[s.bit_idx];
                next_s.bit_idx    = s.bit_idx + 3'd1;
                if (s.st == PRSC_CH_DATA && s.bit_idx == PRSC_STROBE_END) begin
                    next_s.strobe = 1'b0;
                end
                if (s.bit_idx == PRSC_BIT_MSB) begin
                    unique case (s.st)
                        PRSC_RD_DATA: begin
                            if (s.addr == PRSC_ADDR_PRE_PIN) begin
                                pins_now    = i_port_pins;
                                next_s.pins = i_port_pins;
                            end
                            if (s.addr == PRSC_ADDR_LAST) begin
                                next_s.st     = PRSC_RD_CRC;
                                next_s.shreg  = ~crc[7:0];
                                next_s.crc_hi = 1'b1;
                            end else begin
                                next_s.addr   = s.addr + 16'h0001;
                                next_s.shreg  = reg_byte(s.addr + 16'h0001, pins_now, s,
                                                         i_ext_supply);
                                next_s.addcrc = 1'b1;
                            end
                        end
                        PRSC_RD_CRC: begin
                            if (s.crc_hi) begin
                                next_s.shreg  = ~crc[15:8];
                                next_s.crc_hi = 1'b0;
                            end else begin
                                next_s.st    = PRSC_ONES;
                                next_s.shreg = PRSC_ONES_BYTE;
                            end
                        end
                        PRSC_CH_DATA: begin
                            if (s.cnt == PRSC_CH_LAST) begin
                                next_s.st     = PRSC_CH_CRC;
                                next_s.shreg  = ~crc[7:0];
                                next_s.crc_hi = 1'b1;
                            end else begin
                                next_s.cnt    = s.cnt + 5'd1;
                                next_s.shreg  = i_port_pins;
                                next_s.addcrc = 1'b1;
                                next_s.strobe = s.ctl[PRSC_BIT_RPF];
                            end
                        end
                        PRSC_CH_CRC: begin
                            if (s.crc_hi) begin
                                next_s.shreg  = ~crc[15:8];
                                next_s.crc_hi = 1'b0;
                            end else begin
                                // restart: later passes cover samples only
                                crc_clr       = 1'b1;
                                next_s.st     = PRSC_CH_DATA;
                                next_s.cnt    = '0;
                                next_s.shreg  = i_port_pins;
                                next_s.addcrc = 1'b1;
                                next_s.strobe = s.ctl[PRSC_BIT_RPF];
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end

        // conditional search qualification
        src   = s.ctl[PRSC_BIT_SRC] ? i_activity : i_port_pins;
        match = ~(src ^ s.pol);
        next_s.resp = s.ctl[PRSC_BIT_POR] ||
                      (s.ctl[PRSC_BIT_CMB] ? &(~s.mask | match)
                                           : |(s.mask & match));

        next_s.pin_reset = !s.ctl[PRSC_BIT_RPF] && !i_reset_strobe_pin_in;

        if (i_od_enter) begin
            next_s.od = 1'b1;
        end else if (i_od_leave) begin
            next_s.od = 1'b0;
        end

        if (i_bus_reset) begin
            next_s.st     = PRSC_IDLE;
            next_s.strobe = 1'b0;
            next_s.addcrc = 1'b0;
            next_s.crc_hi = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            s <= STATE_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign o_tx              = s.tx;
    assign o_reset_strobe_pin_out        = 1'b0;
    assign o_reset_strobe_pin_oe         = s.strobe;
    assign o_pin_reset       = s.pin_reset;
    assign o_search_response = s.resp;
    assign o_overdrive_flag  = s.od;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    ctrl_write_only_a: assert property ($changed(s.ctl) |-> $past(s.st) == PRSC_WR_DATA)
        else $error("control register changed outside a search register write");
    reset_value_a: assert property ($rose(i_rst_n) |-> s.ctl == PRSC_CTRL_RESET)
        else $error("control register not 08h after reset");
    reserved_read_a: assert property (
        (i_read_slot && s.st == PRSC_RD_DATA && s.addr == PRSC_ADDR_CTRL
         && s.bit_idx inside {3'd4, 3'd5, 3'd6}) |=> !o_tx.bit_val)
        else $error("reserved control bit read as one");
    por_no_set_a: assert property (!$rose(s.ctl[PRSC_BIT_POR]))
        else $error("power-on flag set after reset");
    por_answers_a: assert property (s.ctl[PRSC_BIT_POR] |=> o_search_response)
        else $error("power-on flag set but search not answered");
    search_or_a: assert property (
        (!s.ctl[PRSC_BIT_CMB] && !s.ctl[PRSC_BIT_SRC]
         && |(s.mask & ~(i_port_pins ^ s.pol))) |=> o_search_response)
        else $error("OR qualification missed");
    search_and_a: assert property (
        (s.ctl[PRSC_BIT_CMB] && !s.ctl[PRSC_BIT_POR] && !s.ctl[PRSC_BIT_SRC]
         && !(&(~s.mask | ~(i_port_pins ^ s.pol)))) |=> !o_search_response)
        else $error("AND qualification answered with a mismatch");
    ones_after_crc_a: assert property ((i_read_slot && s.st == PRSC_ONES)
        |=> o_tx.valid && o_tx.bit_val)
        else $error("read slot after CRC did not answer one");
    ch_crc_insert_a: assert property (
        (i_read_slot && !i_bus_reset && s.st == PRSC_CH_DATA && s.cnt == PRSC_CH_LAST
         && s.bit_idx == PRSC_BIT_MSB) |=> s.st == PRSC_CH_CRC ##0 s.shreg == ~crc[7:0])
        else $error("CRC not inserted after 32 samples");
    bus_abort_a: assert property (i_bus_reset |=> s.st == PRSC_IDLE && !o_reset_strobe_pin_oe)
        else $error("bus reset did not abort the command");
    strobe_ends_a: assert property (
        (o_reset_strobe_pin_oe && i_read_slot && s.bit_idx == PRSC_STROBE_END) |=> !o_reset_strobe_pin_oe)
        else $error("strobe longer than two bits");
    od_enter_a: assert property (i_od_enter |=> o_overdrive_flag)
        else $error("overdrive not entered");
endmodule

// file: bench/prsc_master_model.sv
`timescale 1ns/1ps
module prsc_master_model (
    input  wire logic               i_ref_clk,
    input  wire logic               i_ready,
    output prsc_pkg::prsc_byte_type o_rx,
    output logic                    o_slot,
    output logic                    o_bus_reset
);
    import prsc_pkg::*;
    initial begin
        o_rx = '0;
        o_slot = 1'b0;
        o_bus_reset = 1'b0;
    end
    // byte held until taken, then data line shows inverse
    task automatic send(input logic [7:0] b);
        o_rx = {1'b1, b};
        do @(posedge i_ref_clk); while (!i_ready);
        #1 o_rx = {1'b0, ~b};
        @(posedge i_ref_clk);
        #1;
    endtask
    task automatic pulse(input logic rst);
        o_bus_reset = rst;
        o_slot = !rst;
        @(posedge i_ref_clk);
        #1 {o_bus_reset, o_slot} = 2'b00;
        @(posedge i_ref_clk);
        #1;
    endtask
endmodule

// file: bench/prsc_ctrl_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fails++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module prsc_ctrl_tb_top;
    import prsc_pkg::*;
    logic clk = 0, rst_n = 0, ext = 0, ready, slot, brst, resp, rz, oe, prst, od;
    logic oden = 0, odlv = 0, rzin = 1, ex;
    logic [7:0] pins = 0, act = 0, lat = 0, sh, e, hit, pg [8];
    logic [15:0] c, k;
    prsc_byte_type rx;
    prsc_tx_type tx;
    logic [7:0] expq[$];
    int fails = 0, checks_done = 0, cyc = 0, nb = 0, seed = 32'h87e7;
    always #50 clk = ~clk;
    prsc_ctrl u_prsc_ctrl (.i_ref_clk(clk), .i_rst_n(rst_n), .i_bus_reset(brst),
        .i_od_enter(oden), .i_od_leave(odlv), .i_rx(rx), .o_rx_ready(ready),
        .i_read_slot(slot), .o_tx(tx), .i_port_pins(pins), .i_output_latch(lat),
        .i_activity(act), .i_ext_supply(ext), .i_reset_strobe_pin_in(rzin), .o_reset_strobe_pin_out(rz),
        .o_reset_strobe_pin_oe(oe), .o_pin_reset(prst), .o_search_response(resp), .o_overdrive_flag(od));
    prsc_master_model u_m (.i_ref_clk(clk), .i_ready(ready), .o_rx(rx), .o_slot(slot),
        .o_bus_reset(brst));
    always @(posedge clk) if (tx.valid === 1'b1) begin
        sh = {tx.bit_val, sh[7:1]};
        if (++nb == 8) begin
            nb = 0;
            e = expq.size() ? expq.pop_front() : 8'hxx;
            `CHK(sh, e)
        end
    end
    always @(posedge clk) if (++cyc == 5000) begin fails++; stop_test(); end
    function automatic logic [15:0] crc(input logic [15:0] v, input logic [7:0] b);
        v ^= {8'h00, b};
        repeat (8) v = v[0] ? (v >> 1) ^ PRSC_CRC_POLY : v >> 1;
        return v;
    endfunction
    task automatic note(input logic [7:0] b);
        expq.push_back(b);
        c = crc(c, b);
    endtask
    task automatic cmd(input logic [7:0] op, input logic [15:0] a, input logic wa);
        c = crc(16'h0000, op);
        u_m.send(op);
        if (wa) begin
            c = crc(crc(c, a[7:0]), a[15:8]);
            u_m.send(a[7:0]);
            u_m.send(a[15:8]);
        end
    endtask
    task automatic tail(input int n, input logic ones);
        k = ~c;
        note(k[7:0]);
        note(k[15:8]);
        repeat (2 * ones) note(8'hFF);
        repeat (3) @(posedge clk);
        #1;
        repeat (8 * n) u_m.pulse(1'b0);
        u_m.pulse(1'b1);
    endtask
    task automatic read_page(input logic [7:0] lo);
        cmd(PRSC_CMD_READ_REGS, {8'h00, lo}, 1'b1);
        for (int a = lo; a <= 8'h8F; a++) note(pg[a - 8'h88]);
        tail(8'h94 - lo, 1'b1);
        $display("test read from %h done", lo);
    endtask
    task automatic wr(input logic [7:0] m, p, w);
        cmd(PRSC_CMD_WR_SEARCH, PRSC_ADDR_MASK, 1'b1);
        u_m.send(m);
        u_m.send(p);
        u_m.send(w);
        u_m.send(8'h5A);
        repeat (3) @(posedge clk);
        #1 u_m.pulse(1'b1);
        pg[3] = m;
        pg[4] = p;
        pg[5] = {ext, 4'b0000, w[2:0]};
    endtask
    task automatic stop_test();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        #1 rst_n = 1'b1;
        pg = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'hFF, 8'hFF};
        read_page(8'h8D);
        `CHK(resp, 1'b1)
        `CHK(od, 1'b0)
        oden = 1'b1;
        @(posedge clk);
        #1 oden = 1'b0;
        `CHK(od, 1'b1)
        odlv = 1'b1;
        @(posedge clk);
        #1 odlv = 1'b0;
        `CHK(od, 1'b0)
        for (int m = 0; m < 8; m++) begin
            ext = m[0];
            wr(m[2] ? 8'h10 : $random(seed), $random(seed), 8'hF0 | m[2:0]);
            repeat (4) begin
                {rzin, act, pins} = 17'($random(seed));
                hit = ((m[0] ? act : pins) ~^ pg[4]) & pg[3];
                ex = m[1] ? hit == pg[3] : |hit;
                repeat (2) @(posedge clk);
                #1 `CHK(resp, ex)
                `CHK(prst, !m[2] && !rzin)
            end
        end
        $display("test search done");
        lat = 8'($random(seed));
        pg[0] = pins;
        pg[1] = lat;
        pg[2] = act;
        read_page(8'h88);
        cmd(PRSC_CMD_CH_READ, 16'h0000, 1'b0);
        `CHK(oe, 1'b1)
        `CHK(rz, 1'b0)
        repeat (32) note(pins);
        tail(34, 1'b0);
        `CHK(oe, 1'b0)
        $display("test channel read done");
        `CHK(expq.size(), 0)
        stop_test();
    end
endmodule
